// [hdl/pph_ports.sv]
`timescale 1ns/1ps
// Notes on behaviour
// [RQ1] Port 1 direction bit 1 makes its pin output, 0 makes it input.
// [RQ2] Without alternate function a Port 1 pin is plain I/O per direction.
// [RQ3] Handshake mode: bit 0 is strobe/acknowledge in, bit 1 flag out.
// [RQ4] Output handshake: host write drops flag low, acknowledge raises it.
// [RQ5] Peripheral reads the byte, then pulls acknowledge low.
// [RQ6] Input handshake: strobe low drives the input flag low.
// [RQ7] Input handshake: Port 2 data latched on strobe rising edge.
// [RQ8] Input handshake: host read of Port 2 raises the input flag.
// [RQ9] Event counter selects make bits 2 and 3 the counter inputs.
// [RQ10] Bit 4 outputs baud clock in test mode, select above 2, dir 1.
// [RQ11] Test clock is 64x bit rate, 32x at the fastest rate.
// [RQ12] Trigger select: falling edge on bit 5 reloads and starts timer 5.
// [RQ13] Break-in enabled: bit 6 low during last stop bit signals break-in.
// [RQ14] Pin-7 option: each rising edge on bit 7 requests level 1.
// [RQ15] Port 1 writes always update latch; inputs show it once outputs.
// [RQ16] Port 1 pins used as control keep their pin despite writes.
// [RQ17] Host read of Port 1 returns Port 1 data.
// [RQ18] Port 2 writes load latch; input pins stay unaffected.
// [RQ19] Port 2 read: pin level for inputs, latch for outputs.
// [RQ20] In handshake mode level 7 serves Port 2 instead of timer 5.
// [RQ21] Software reset raises both flags when in handshake mode.
// [RQ22] Output handshake drives all Port 2 pins; input handshake none.
// [RQ23] Acknowledge sampled on clk_sys; low raises flag next edge.
module pph_ports (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // Host register port
    input wire logic [3:0] host_addr,
    input wire logic host_rd,
    input wire logic host_wr,
    input wire logic [7:0] host_wdata,
    output logic [7:0] host_rdata,
    // Configuration from the other device registers
    input wire pph_pkg::pph_cfg_t cfg,
    input wire logic soft_reset_cmd,
    // Serial unit and timer hooks
    input wire logic baud_tick_x64,
    input wire logic baud_tick_x32,
    input wire logic tx_last_stop_bit,
    input wire logic timer5_irq_req,
    output pph_pkg::pph_evt_t evt,
    // Port 1 pins
    input wire logic [7:0] port1_in,
    output logic [7:0] port1_out,
    output logic [7:0] port1_oe_n,
    // Port 2 pins
    input wire logic [7:0] port2_in,
    output logic [7:0] port2_out,
    output logic [7:0] port2_oe_n
);
    import pph_pkg::*;

    logic [7:0] port_one_direction_reg;
    logic [7:0] port_one_latch_reg;
    logic [7:0] port_two_latch_reg;
    logic [7:0] port_two_strobed_reg;
    logic [7:0] p1_sync;
    logic [7:0] p2_sync;
    logic [7:0] p1_prev_reg;
    logic input_buffer_full_flag_reg;
    logic output_buffer_full_flag_reg;
    logic baud_clk_reg;
    logic hs_mode;
    logic hs_in_mode;
    logic hs_out_mode;
    logic test_clk_on;
    logic wr_port_two;
    logic rd_port_two;
    logic strobe_fall;
    logic strobe_rise;
    logic [7:0] p1_alt_ctrl;
    logic [7:0] p1_drive;
    logic [7:0] p2_drive;
    logic [7:0] p1_read;
    logic [7:0] p2_read;
    logic [7:0] rdata_next;
    pph_evt_t evt_next;

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers; pins idle high so reset to ones
    pph_sync #(.WIDTH(8), .RESET_VAL(PPH_RST_PINSYNC)) u_sync_p1 (
        .clk_sys(clk_sys),
        .reset(reset),
        .async_in(port1_in),
        .sync_out(p1_sync)
    );

    pph_sync #(.WIDTH(8), .RESET_VAL(PPH_RST_PINSYNC)) u_sync_p2 (
        .clk_sys(clk_sys),
        .reset(reset),
        .async_in(port2_in),
        .sync_out(p2_sync)
    );

    // Address decode used by both the write and the read paths
    function automatic logic hit(input logic [3:0] a, input logic [3:0] ofs);
        hit = (a == ofs);
    endfunction : hit

    ////////////////////////////////////////////////////////////////////////
    // Mode decode
    assign hs_in_mode = (cfg.port2_mode == PPH_P2_HS_IN);
    assign hs_out_mode = (cfg.port2_mode == PPH_P2_HS_OUT);
    assign hs_mode = hs_in_mode | hs_out_mode;
    // [RQ10] test clock gating
    assign test_clk_on = (cfg.port2_mode == PPH_P2_TEST)
        && (cfg.baud_rate_select > PPH_BAUD_SEL_TEST_MIN)
        && port_one_direction_reg[PPH_BIT_BAUD];
    assign wr_port_two = host_wr && hit(host_addr, PPH_OFS_PORT_TWO_DATA);
    assign rd_port_two = host_rd && hit(host_addr, PPH_OFS_PORT_TWO_DATA);
    // Strobe edges taken from synchronised levels only
    assign strobe_fall = p1_prev_reg[PPH_BIT_STROBE]
        && !p1_sync[PPH_BIT_STROBE];
    assign strobe_rise = !p1_prev_reg[PPH_BIT_STROBE]
        && p1_sync[PPH_BIT_STROBE];

    ////////////////////////////////////////////////////////////////////////
    // Port 1 direction register
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            port_one_direction_reg <= PPH_RST_DIRECTION;
        end else if (host_wr && hit(host_addr, PPH_OFS_PORT_ONE_DIRECTION)) begin
            port_one_direction_reg <= host_wdata;
        end
    end

    // Port 1 output latch
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            port_one_latch_reg <= PPH_RST_LATCH;
        // [RQ15] latch every bit
        end else if (host_wr && hit(host_addr, PPH_OFS_PORT_ONE_DATA)) begin
            port_one_latch_reg <= host_wdata;
        end
    end

    // Port 2 output latch, written whatever the pin directions
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            port_two_latch_reg <= PPH_RST_LATCH;
        // [RQ18] latch always loads
        end else if (wr_port_two) begin
            port_two_latch_reg <= host_wdata;
        end
    end

    // Previous synchronised Port 1 levels for edge detection
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            p1_prev_reg <= PPH_RST_PINSYNC;
        end else begin
            p1_prev_reg <= p1_sync;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Input handshake data capture
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            port_two_strobed_reg <= PPH_RST_LATCH;
        // [RQ7] capture on strobe rise
        end else if (hs_in_mode && strobe_rise) begin
            port_two_strobed_reg <= p2_sync;
        end
    end

    // Input buffer full flag, active low; a strobe wins over a read
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            input_buffer_full_flag_reg <= PPH_RST_FLAG;
        // [RQ6] strobe low drops flag
        end else if (hs_in_mode && strobe_fall) begin
            input_buffer_full_flag_reg <= 1'b0;
        // [RQ21] software reset raises flag
        end else if (hs_mode && soft_reset_cmd) begin
            input_buffer_full_flag_reg <= 1'b1;
        // [RQ8] host read raises flag
        end else if (hs_in_mode && rd_port_two) begin
            input_buffer_full_flag_reg <= 1'b1;
        end
    end

    // Output buffer full flag, active low; a write wins over acknowledge
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            output_buffer_full_flag_reg <= PPH_RST_FLAG;
        // [RQ4] host write drops flag
        end else if (hs_out_mode && wr_port_two) begin
            output_buffer_full_flag_reg <= 1'b0;
        // [RQ21] software reset raises flag
        end else if (hs_mode && soft_reset_cmd) begin
            output_buffer_full_flag_reg <= 1'b1;
        // [RQ23] sampled acknowledge raises flag
        end else if (hs_out_mode && !p1_sync[PPH_BIT_STROBE]) begin
            output_buffer_full_flag_reg <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Baud test clock: toggling on each tick halves the tick rate, so the
    // generator supplies ticks at twice the wanted pin frequency
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            baud_clk_reg <= 1'b0;
        // [RQ11] 32x tick at fastest rate
        end else if (cfg.baud_rate_select == PPH_BAUD_SEL_FASTEST) begin
            baud_clk_reg <= baud_clk_reg ^ baud_tick_x32;
        end else begin
            baud_clk_reg <= baud_clk_reg ^ baud_tick_x64;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Which Port 1 pins are held by an alternate control function
    always_comb begin
        p1_alt_ctrl = 8'h00;
        // [RQ3] handshake takes bits 0 and 1
        p1_alt_ctrl[PPH_BIT_STROBE] = hs_mode;
        p1_alt_ctrl[PPH_BIT_FLAG] = hs_mode;
        // [RQ9] counter inputs
        p1_alt_ctrl[PPH_BIT_CNT2] = cfg.counter2_event_select;
        p1_alt_ctrl[PPH_BIT_CNT3] = cfg.counter3_event_select;
        p1_alt_ctrl[PPH_BIT_BAUD] = test_clk_on;
        p1_alt_ctrl[PPH_BIT_T5TRIG] = cfg.timer5_trigger_select;
        p1_alt_ctrl[PPH_BIT_BRKIN] = cfg.break_in_detect_enable;
        p1_alt_ctrl[PPH_BIT_IRQ] = cfg.pin_seven_irq_enable;
    end

    // Port 1 pin drive; control inputs are never driven
    always_comb begin
        // [RQ1] direction bit selects drive
        // [RQ2] plain I/O without alternate use
        p1_drive = port_one_direction_reg & ~p1_alt_ctrl;
        port1_out = port_one_latch_reg;
        // [RQ16] control pins ignore the latch
        port1_out[PPH_BIT_FLAG] = port_one_latch_reg[PPH_BIT_FLAG];
        if (hs_mode) begin
            p1_drive[PPH_BIT_FLAG] = 1'b1;
            port1_out[PPH_BIT_FLAG] = hs_in_mode ? input_buffer_full_flag_reg
                : output_buffer_full_flag_reg;
        end
        if (test_clk_on) begin
            p1_drive[PPH_BIT_BAUD] = 1'b1;
            port1_out[PPH_BIT_BAUD] = baud_clk_reg;
        end
        port1_oe_n = ~p1_drive;
    end

    // Port 2 pin drive per mode; test and unused codes leave it floating
    always_comb begin
        unique case (cfg.port2_mode)
            PPH_P2_NIB_II: p2_drive = 8'h00;
            PPH_P2_NIB_IO: p2_drive = 8'h0F;
            PPH_P2_NIB_OI: p2_drive = 8'hF0;
            PPH_P2_NIB_OO: p2_drive = 8'hFF;
            // [RQ22] handshake drives all or none
            PPH_P2_HS_IN: p2_drive = 8'h00;
            PPH_P2_HS_OUT: p2_drive = 8'hFF;
            PPH_P2_UNUSED: p2_drive = 8'h00;
            PPH_P2_TEST: p2_drive = 8'h00;
        endcase
        port2_out = port_two_latch_reg;
        port2_oe_n = ~p2_drive;
    end

    ////////////////////////////////////////////////////////////////////////
    // Read data: driven bits show the pin drive value, others the pin; input handshake reads the strobed byte
    always_comb begin
        // [RQ17] Port 1 read value
        p1_read = (p1_drive & port1_out) | (~p1_drive & p1_sync);
        // [RQ19] Port 2 mix of pins and latch
        p2_read = (p2_drive & port_two_latch_reg) | (~p2_drive & p2_sync);
        if (hs_in_mode) begin
            p2_read = port_two_strobed_reg;
        end
        rdata_next = PPH_UNMAPPED_READ;
        if (hit(host_addr, PPH_OFS_PORT_ONE_DIRECTION)) begin
            rdata_next = port_one_direction_reg;
        end else if (hit(host_addr, PPH_OFS_PORT_ONE_DATA)) begin
            rdata_next = p1_read;
        end else if (hit(host_addr, PPH_OFS_PORT_TWO_DATA)) begin
            rdata_next = p2_read;
        end
    end

    // Read data register holds until the next read
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            host_rdata <= PPH_UNMAPPED_READ;
        end else if (host_rd) begin
            host_rdata <= rdata_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Event decode from synchronised pins; edge events are one-cycle pulses
    always_comb begin
        // [RQ9] counters count rising edges
        evt_next.counter2_event = cfg.counter2_event_select
            && !p1_prev_reg[PPH_BIT_CNT2] && p1_sync[PPH_BIT_CNT2];
        evt_next.counter3_event = cfg.counter3_event_select
            && !p1_prev_reg[PPH_BIT_CNT3] && p1_sync[PPH_BIT_CNT3];
        // [RQ12] falling edge trigger
        evt_next.timer5_trigger = cfg.timer5_trigger_select
            && p1_prev_reg[PPH_BIT_T5TRIG] && !p1_sync[PPH_BIT_T5TRIG];
        // [RQ13] break-in during last stop bit
        evt_next.break_in = cfg.break_in_detect_enable && tx_last_stop_bit
            && !p1_sync[PPH_BIT_BRKIN];
        // [RQ14] edge not level on bit 7
        evt_next.irq_level1 = cfg.pin_seven_irq_enable
            && !p1_prev_reg[PPH_BIT_IRQ] && p1_sync[PPH_BIT_IRQ];
        // [RQ20] level 7 source: a byte taken or a byte latched
        if (hs_out_mode) begin
            evt_next.irq_level7 = !output_buffer_full_flag_reg
                && !p1_sync[PPH_BIT_STROBE] && !wr_port_two
                && !soft_reset_cmd;
        end else if (hs_in_mode) begin
            evt_next.irq_level7 = strobe_rise;
        end else begin
            evt_next.irq_level7 = timer5_irq_req;
        end
    end

    // Registered events toward the rest of the device
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            evt <= '0;
        end else begin
            evt <= evt_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    sequence s_port2_write;
        hs_out_mode && wr_port_two;
    endsequence

    sequence s_ack_low;
        hs_out_mode && !wr_port_two && !soft_reset_cmd
            && !p1_sync[PPH_BIT_STROBE];
    endsequence

    a_obf_write_low: assert property ( // [RQ4]
        s_port2_write |=> !output_buffer_full_flag_reg)
        else $error("output flag not low after port 2 write");

    a_obf_ack_high: assert property ( // [RQ23]
        s_ack_low |=> output_buffer_full_flag_reg)
        else $error("output flag not high after acknowledge");

    a_ibf_strobe_low: assert property ( // [RQ6]
        hs_in_mode && strobe_fall |=> !input_buffer_full_flag_reg)
        else $error("input flag not low after strobe");

    a_ibf_read_high: assert property ( // [RQ8]
        hs_in_mode && rd_port_two && !strobe_fall
            |=> input_buffer_full_flag_reg)
        else $error("input flag not high after port 2 read");

    a_strobe_capture: assert property ( // [RQ7]
        hs_in_mode && strobe_rise |=> port_two_strobed_reg == $past(p2_sync))
        else $error("port 2 data not captured on strobe rise");

    a_flag_pin_drive: assert property ( // [RQ3]
        hs_out_mode |-> !port1_oe_n[PPH_BIT_FLAG]
            && port1_out[PPH_BIT_FLAG] == output_buffer_full_flag_reg)
        else $error("flag pin not driven from output flag");

    a_strobe_pin_input: assert property ( // [RQ3]
        hs_mode |-> port1_oe_n[PPH_BIT_STROBE])
        else $error("strobe pin driven in handshake mode");

    a_p1_plain_dir: assert property ( // [RQ1]
        p1_alt_ctrl == 8'h00 |-> port1_oe_n == ~port_one_direction_reg)
        else $error("port 1 drive does not follow direction");

    a_p1_write_latch: assert property ( // [RQ15]
        host_wr && host_addr == PPH_OFS_PORT_ONE_DATA
            |=> port_one_latch_reg == $past(host_wdata))
        else $error("port 1 latch not updated by write");

    a_baud_pin: assert property ( // [RQ10]
        !test_clk_on && !port_one_direction_reg[PPH_BIT_BAUD]
            |-> port1_oe_n[PPH_BIT_BAUD])
        else $error("baud pin driven without test output");

    a_p7_edge_irq: assert property ( // [RQ14]
        cfg.pin_seven_irq_enable && evt.irq_level1 |=> !evt.irq_level1)
        else $error("level 1 request held longer than one cycle");

    a_p2_hs_drive: assert property ( // [RQ22]
        hs_out_mode |-> port2_oe_n == 8'h00 ##0 hs_out_mode)
        else $error("port 2 not fully driven in output handshake");

    a_soft_reset: assert property ( // [RQ21]
        hs_mode && soft_reset_cmd && !wr_port_two && !strobe_fall
            |=> input_buffer_full_flag_reg && output_buffer_full_flag_reg)
        else $error("flags not raised by software reset");

endmodule : pph_ports

// [hdl/pph_pkg.sv]
package pph_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Register offsets on the host port
    localparam logic [3:0] PPH_OFS_PORT_ONE_DIRECTION = 4'h4;
    localparam logic [3:0] PPH_OFS_PORT_ONE_DATA = 4'h8;
    localparam logic [3:0] PPH_OFS_PORT_TWO_DATA = 4'h9;

    // Values after reset
    localparam logic [7:0] PPH_RST_DIRECTION = 8'h00;
    localparam logic [7:0] PPH_RST_LATCH = 8'h00;
    localparam logic [7:0] PPH_RST_PINSYNC = 8'hFF;
    localparam logic PPH_RST_FLAG = 1'b1;
    localparam logic [7:0] PPH_UNMAPPED_READ = 8'h00;

    // Port 1 bit positions of the alternate functions
    localparam int PPH_BIT_STROBE = 0;
    localparam int PPH_BIT_FLAG = 1;
    localparam int PPH_BIT_CNT2 = 2;
    localparam int PPH_BIT_CNT3 = 3;
    localparam int PPH_BIT_BAUD = 4;
    localparam int PPH_BIT_T5TRIG = 5;
    localparam int PPH_BIT_BRKIN = 6;
    localparam int PPH_BIT_IRQ = 7;

    // Baud select codes: test output needs a code above this one
    localparam logic [3:0] PPH_BAUD_SEL_TEST_MIN = 4'h2;
    // Code of the highest bit rate, where the test clock is 32x
    localparam logic [3:0] PPH_BAUD_SEL_FASTEST = 4'hF;

    // Port 2 control field
    typedef enum logic [2:0] {
        PPH_P2_NIB_II = 3'b000,
        PPH_P2_NIB_IO = 3'b001,
        PPH_P2_NIB_OI = 3'b010,
        PPH_P2_NIB_OO = 3'b011,
        PPH_P2_HS_IN = 3'b100,
        PPH_P2_HS_OUT = 3'b101,
        PPH_P2_UNUSED = 3'b110,
        PPH_P2_TEST = 3'b111
    } pph_p2_mode_t;

    // Configuration bits held by the device's other registers
    typedef struct packed {
        pph_p2_mode_t port2_mode;
        logic counter2_event_select;
        logic counter3_event_select;
        logic timer5_trigger_select;
        logic cascade_two_four;
        logic cascade_three_five;
        logic break_in_detect_enable;
        logic pin_seven_irq_enable;
        logic [3:0] baud_rate_select;
    } pph_cfg_t;

    // Events handed to timers, serial unit and interrupt controller
    typedef struct packed {
        logic counter2_event;
        logic counter3_event;
        logic timer5_trigger;
        logic break_in;
        logic irq_level1;
        logic irq_level7;
    } pph_evt_t;

endpackage : pph_pkg

// [hdl/pph_sync.sv]
`timescale 1ns/1ps
module pph_sync #(
    parameter int WIDTH = 8,
    parameter logic [WIDTH-1:0] RESET_VAL = '1
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic reset,
    // Asynchronous levels in, synchronised levels out
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] stage1_reg;

    ////////////////////////////////////////////////////////////////////////
    // Two flops; first stage feeds only the second
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            stage1_reg <= RESET_VAL;
            sync_out <= RESET_VAL;
        end else begin
            stage1_reg <= async_in;
            sync_out <= stage1_reg;
        end
    end

endmodule : pph_sync

// [testbench/pph_peer.sv]
`timescale 1ns/1ps
module pph_peer (
    // Clock
    input wire logic clk_sys,
    // Device side of the byte handshake
    input wire logic out_mode,
    input wire logic flag,
    input wire logic [7:0] pins,
    output logic strobe_n,
    output logic [7:0] data,
    output logic [7:0] got
);
    // Idle: strobe high, a known byte on the data lines
    initial begin
        strobe_n = 1'b1;
        data = 8'hA0;
        got = 8'h00;
    end
    ////////////////////////////////////////////////////////////////////////
    // Output side: take the byte, then hold acknowledge until flag returns
    // read then acknowledge
    always @(posedge clk_sys) begin
        if (out_mode && flag === 1'b0 && strobe_n) begin
            repeat (2) @(posedge clk_sys);
            got <= pins;
            strobe_n <= 1'b0;
            while (flag !== 1'b1) @(posedge clk_sys);
            strobe_n <= 1'b1;
        end
    end
    // Input side: byte stays put across the strobe rise, then is dropped
    // valid at rise
    task send(input logic [7:0] b);
        @(posedge clk_sys);
        data <= b;
        strobe_n <= 1'b0;
        repeat (6) @(posedge clk_sys);
        strobe_n <= 1'b1;
        repeat (6) @(posedge clk_sys);
        data <= ~b;
    endtask : send
endmodule : pph_peer

// [testbench/pph_ports_tb.sv]
`timescale 1ns/1ps
module pph_ports_tb;
    import pph_pkg::*;
    logic clk_sys, reset, host_rd, host_wr, soft_reset_cmd;
    logic [3:0] host_addr;
    logic [7:0] host_wdata, host_rdata, rd_val;
    pph_cfg_t cfg;
    pph_evt_t evt;
    logic tick64, tick32, last_stop, strobe_n, clr, prev, t5_req;
    logic [7:0] port1_in, port1_out, port1_oe_n, p1_drv;
    logic [7:0] port2_in, port2_out, port2_oe_n, peer_data, peer_got;
    logic [5:0] seen;
    int fail_count, checks_done;

    pph_ports DUT (.clk_sys(clk_sys), .reset(reset), .host_addr(host_addr),
        .host_rd(host_rd), .host_wr(host_wr), .host_wdata(host_wdata),
        .host_rdata(host_rdata), .cfg(cfg), .soft_reset_cmd(soft_reset_cmd),
        .baud_tick_x64(tick64), .baud_tick_x32(tick32),
        .tx_last_stop_bit(last_stop), .timer5_irq_req(t5_req), .evt(evt),
        .port1_in(port1_in), .port1_out(port1_out), .port1_oe_n(port1_oe_n),
        .port2_in(port2_in), .port2_out(port2_out), .port2_oe_n(port2_oe_n));
    pph_peer PEER (.clk_sys(clk_sys),
        .out_mode(cfg.port2_mode == PPH_P2_HS_OUT), .flag(port1_out[1]),
        .pins(port2_in), .strobe_n(strobe_n), .data(peer_data),
        .got(peer_got));

    // Wire levels: driven bits read back the device, the rest the outside
    assign port1_in = (port1_out & ~port1_oe_n)
        | ({p1_drv[7:1], strobe_n} & port1_oe_n);
    assign port2_in = (port2_out & ~port2_oe_n) | (peer_data & port2_oe_n);
    // Sticky record of event pulses, since edge events last one cycle only
    always @(posedge clk_sys) seen <= clr ? 6'h00 : (seen | evt);
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end
    ////////////////////////////////////////////////////////////////////////
    task chk(input logic [7:0] e, input logic [7:0] g);
        checks_done++;
        if (g !== e) begin
            fail_count++;
            $display("[ERR] t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask : chk
    task wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        host_addr <= a;
        host_wdata <= d;
        host_wr <= 1'b1;
        @(posedge clk_sys);
        host_wr <= 1'b0;
    endtask : wr
    task rd(input logic [3:0] a);
        @(posedge clk_sys);
        host_addr <= a;
        host_rd <= 1'b1;
        @(posedge clk_sys);
        host_rd <= 1'b0;
        @(negedge clk_sys);
        rd_val = host_rdata;
    endtask : rd
    task mark;
        @(posedge clk_sys);
        clr <= 1'b1;
        @(posedge clk_sys);
        clr <= 1'b0;
    endtask : mark
    // Move one pin, then look for the events in mask m over six cycles
    task pev(input int b, input logic v, input logic [5:0] m, e);
        @(posedge clk_sys);
        clr <= 1'b1;
        p1_drv[b] <= v;
        @(posedge clk_sys);
        clr <= 1'b0;
        repeat (5) @(posedge clk_sys);
        @(negedge clk_sys);
        chk({2'b00, e}, {2'b00, seen & m});
    endtask : pev
    // One baud tick must turn the test clock pin over
    task btk(input logic fast);
        @(negedge clk_sys);
        prev = port1_out[4];
        @(posedge clk_sys);
        if (fast) tick32 <= 1'b1;
        else tick64 <= 1'b1;
        @(posedge clk_sys);
        tick32 <= 1'b0;
        tick64 <= 1'b0;
        @(negedge clk_sys);
        chk({7'h00, ~prev}, {7'h00, port1_out[4]});
    endtask : btk
    task flag_is(input logic f);
        @(negedge clk_sys);
        chk({7'h00, f}, {7'h00, port1_out[1]});
    endtask : flag_is
    task conclude;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : conclude
    // Tests take about 140 cycles; 5000, some thirty-five times that, means a hang
    initial begin
        repeat (5000) @(posedge clk_sys);
        fail_count++;
        conclude();
    end
    ////////////////////////////////////////////////////////////////////////
    initial begin
        {reset, host_rd, host_wr, soft_reset_cmd, clr} = 5'b10000;
        {host_addr, host_wdata, tick64, tick32, last_stop, t5_req} = '0;
        cfg = '0;
        p1_drv = 8'h3F;
        fail_count = 0;
        checks_done = 0;
        repeat (6) @(posedge clk_sys);
        reset <= 1'b0;
        rd(PPH_OFS_PORT_ONE_DIRECTION);
        chk(8'h00, rd_val);
        chk(8'hFF, port1_oe_n);
        wr(PPH_OFS_PORT_ONE_DATA, 8'hA5);
        wr(PPH_OFS_PORT_ONE_DIRECTION, 8'h0F);
        @(negedge clk_sys);
        chk(8'hF0, port1_oe_n);
        chk(8'h05, port1_out & 8'h0F);
        rd(PPH_OFS_PORT_ONE_DATA);
        chk(8'h35, rd_val);
        wr(PPH_OFS_PORT_ONE_DIRECTION, 8'hFF);
        @(negedge clk_sys);
        chk(8'hA5, port1_out);
        rd(4'h3);
        chk(PPH_UNMAPPED_READ, rd_val);
        $display("port 1 test done");
        cfg.port2_mode <= PPH_P2_NIB_IO;
        wr(PPH_OFS_PORT_TWO_DATA, 8'h3C);
        @(negedge clk_sys);
        chk(8'hF0, port2_oe_n);
        chk(8'h0C, port2_out & 8'h0F);
        rd(PPH_OFS_PORT_TWO_DATA);
        chk(8'hAC, rd_val);
        $display("port 2 test done");
        wr(PPH_OFS_PORT_ONE_DIRECTION, 8'h00);
        cfg.port2_mode <= PPH_P2_HS_OUT;
        mark();
        wr(PPH_OFS_PORT_TWO_DATA, 8'h5A);
        @(negedge clk_sys);
        chk(8'h00, {6'h00, port1_out[1], port1_oe_n[1]});
        chk(8'h00, port2_oe_n);
        for (int i = 0; i < 20 && port1_out[1] !== 1'b1; i++) begin
            @(posedge clk_sys);
        end
        flag_is(1'b1);
        chk(8'h5A, peer_got);
        chk(8'h01, {7'h00, seen[0]});
        cfg.port2_mode <= PPH_P2_HS_IN;
        @(negedge clk_sys);
        chk(8'hFF, port2_oe_n);
        PEER.send(8'hC3);
        flag_is(1'b0);
        rd(PPH_OFS_PORT_TWO_DATA);
        chk(8'hC3, rd_val);
        flag_is(1'b1);
        PEER.send(8'h96);
        @(posedge clk_sys);
        soft_reset_cmd <= 1'b1;
        @(posedge clk_sys);
        soft_reset_cmd <= 1'b0;
        flag_is(1'b1);
        t5_req <= 1'b1;
        mark();
        repeat (3) @(posedge clk_sys);
        @(negedge clk_sys);
        chk(8'h00, {7'h00, seen[0]});
        $display("handshake test done");
        cfg <= '{PPH_P2_NIB_II, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1,
            4'h0};
        pev(2, 1'b0, 6'h21, 6'h01);
        pev(2, 1'b1, 6'h20, 6'h20);
        pev(3, 1'b0, 6'h10, 6'h00);
        pev(3, 1'b1, 6'h10, 6'h10);
        pev(5, 1'b0, 6'h08, 6'h08);
        pev(7, 1'b1, 6'h02, 6'h02);
        pev(7, 1'b0, 6'h02, 6'h00);
        pev(6, 1'b0, 6'h04, 6'h00);
        last_stop <= 1'b1;
        pev(6, 1'b0, 6'h04, 6'h04);
        $display("event test done");
        wr(PPH_OFS_PORT_ONE_DIRECTION, 8'h10);
        cfg.port2_mode <= PPH_P2_TEST;
        cfg.baud_rate_select <= 4'h3;
        @(negedge clk_sys);
        chk(8'h00, {7'h00, port1_oe_n[4]});
        btk(1'b0);
        cfg.baud_rate_select <= PPH_BAUD_SEL_TEST_MIN;
        @(negedge clk_sys);
        chk(8'h00, {6'h00, port1_oe_n[4], port1_out[4]});
        cfg.baud_rate_select <= PPH_BAUD_SEL_FASTEST;
        btk(1'b1);
        $display("baud test done");
        conclude();
    end
endmodule : pph_ports_tb
